// ===== common/vmid_map.svh
// Offsets, instruction fields, encodings and reset values of the vector memory decoder.
// Summary of operation
// - Inactive elements make no traffic, no faults.
// - Masked loads keep inactive elements unless agnostic.
// - Start at any element; faults leave start index.
// - Recognised in FP load/store opcodes, mask bit 25.
// - Mask-enable bit zero means masking is active.
// - Indexed: encoded width sizes indices, configuration sizes data.
// - Base address comes from selected scalar register.
// - Unit-stride contiguous; strided adds scalar byte stride.
// - Indexed adds unscaled offsets; offset group multiplier derived.
// - Narrow offsets zero-extended, wide offsets truncated.
// - Unsupported index width raises illegal instruction.
// - Mode field: unit, unordered, strided, ordered.
// - Only indexed-ordered must access in element order.
// - Unordered indexed store faults reported precisely.
// - Load variants plain, whole, mask, fault-first; others reserved.
// - Store variants plain, whole, mask; others reserved.
// - Field count gives fields per element or registers.
// - Effective multiplier outside one eighth..eight is reserved.
// - Vector specifiers must align to group multiplier.
// - Support all configured widths; others illegal.
// - Width codes select vector sizes or scalar FP.
// - Extended width bit set is reserved.
`ifndef VMID_MAP_SVH
`define VMID_MAP_SVH
`define VMID_OFF_INSTR   8'h00
`define VMID_OFF_VTYPE   8'h04
`define VMID_OFF_VLEN    8'h08
`define VMID_OFF_START   8'h0C
`define VMID_OFF_MASK    8'h10
`define VMID_OFF_STATUS  8'h14
`define VMID_OFF_DECODE  8'h18
`define VMID_OFF_OFFV    8'h40
`define VMID_SEL_OFFV    8'hE0
`define VMID_OFF_XREG    8'h80
`define VMID_SEL_XREG    8'h80
`define VMID_VTYPE_RST   32'h80000000
`define VMID_OPC_LOAD    7'h07
`define VMID_OPC_STORE   7'h27
`define VMID_F_OPC       6:0
`define VMID_F_DREG      11:7
`define VMID_F_WIDTH     14:12
`define VMID_F_BASE      19:15
`define VMID_F_SREG      24:20
`define VMID_B_MASK_EN   25
`define VMID_F_MODE      27:26
`define VMID_B_MEW       28
`define VMID_F_FCOUNT    31:29
`define VMID_V_PLAIN     5'h00
`define VMID_V_WHOLE     5'h08
`define VMID_V_MASK      5'h0B
`define VMID_V_FOF       5'h10
`define VMID_B_VILL      31
`define VMID_B_VMA       7
`define VMID_B_EW_HI     5
`define VMID_F_EW        4:3
`define VMID_F_GM        2:0
`define VMID_EW_SUPPORT  4'hF
`define VMID_IDX_SUPPORT 4'hF
`define VMID_MAX_ELEMS   4'h8
`endif

// ===== common/vmid_pkg.sv
// Types shared by the vector memory decoder: states, modes and the state record.
package vmid_pkg;
  typedef enum logic [1:0] {
    vmid_idle   = 2'b00,
    vmid_decode = 2'b01,
    vmid_issue  = 2'b10,
    vmid_wait   = 2'b11
  } vmid_state_type;
  typedef enum logic [1:0] {
    vmid_unit      = 2'b00,
    vmid_idx_unord = 2'b01,
    vmid_strided   = 2'b10,
    vmid_idx_ord   = 2'b11
  } vmid_mode_type;
  typedef struct packed {
    vmid_state_type   state;
    vmid_mode_type    mode;
    logic [31:0]      instr, vtype, base, step, hrdata, req_addr;
    logic [3:0]       vec_len, start_elem, evl, elem;
    logic [7:0]       mask, bus_addr;
    logic             st_done, st_illegal, st_fault, st_fp, st_trim;
    logic             is_load, mask_on, vma, fof, wr_pend, rd_pend, bus_hit;
    logic [1:0]       data_log, idx_log, req_size;
    logic [2:0]       fld_last, fld, req_elem, req_field, dest_elem;
    logic [7:0][31:0] offv;
    logic [31:0][31:0] xreg;
    logic             hreadyout, hresp, req_valid, req_write, req_ordered;
    logic             dest_valid, dest_agnostic;
  } vmid_regs_type;
endpackage

// ===== rtl/vmid_top.sv
// Vector load/store decoder and element address generator behind an AHB-Lite slave.
//
// The AHB-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
`include "vmid_map.svh"
module vmid_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  output logic             mem_req_valid,
  input  wire logic        mem_req_ready,
  output logic [31:0]      mem_req_addr,
  output logic             mem_req_write,
  output logic [1:0]       mem_req_size,
  output logic [2:0]       mem_req_elem,
  output logic [2:0]       mem_req_field,
  output logic             mem_req_ordered,
  input  wire logic        mem_resp_valid,
  input  wire logic        mem_resp_fault,
  output logic             dest_valid,
  output logic [2:0]       dest_elem,
  output logic             dest_agnostic
);

  vmid_pkg::vmid_regs_type r;
  vmid_pkg::vmid_regs_type n;

  // Instruction fields of the latched word.
  logic [6:0]        opc;
  logic [2:0]        wcode;
  logic [1:0]        mode_dec;
  logic [4:0]        variant;
  logic [2:0]        fcount;
  logic [4:0]        dreg;
  logic [4:0]        sreg;
  logic              is_load_dec;
  logic              fp_opc;
  logic              fp_scalar;
  logic              mew;
  logic [1:0]        eew_log;
  logic [1:0]        cfg_ew_log;
  logic signed [3:0] cfg_gm_log;
  logic signed [3:0] eff_gm_log;
  logic signed [3:0] data_gm_log;
  logic [1:0]        whole_log;
  logic              unit;
  logic              indexed;
  logic              mask_x;
  logic              whole;
  logic              fof_dec;
  logic              var_ok;
  logic              cfg_bad;
  logic              gm_bad;
  logic              whole_bad;
  logic              align_bad;
  logic              eew_unsup;
  logic              illegal_dec;
  logic [1:0]        data_log_dec;
  logic [3:0]        evl_dec;
  logic [4:0]        evl_mask;
  logic [31:0]       off_raw;
  logic [31:0]       off_ext;
  logic [31:0]       elem_base;
  logic [31:0]       next_addr;
  logic              active;
  logic [31:0]       rd_data;

  // A group start must be a multiple of the group size; fractional groups fit anywhere.
  function automatic logic grp_ok(input logic [4:0] spec, input logic signed [3:0] lg);
    logic [4:0] low;
    low = (5'h01 << lg[1:0]) - 5'h01;
    grp_ok = (lg <= 4'sd0) || ((spec & low) == 5'h00);
  endfunction

  // Field extraction of the vector memory encoding.
  assign opc         = r.instr[`VMID_F_OPC];
  assign wcode       = r.instr[`VMID_F_WIDTH];
  assign mode_dec    = r.instr[`VMID_F_MODE];
  assign variant     = r.instr[`VMID_F_SREG];
  assign fcount      = r.instr[`VMID_F_FCOUNT];
  assign dreg        = r.instr[`VMID_F_DREG];
  assign sreg        = r.instr[`VMID_F_SREG];
  assign mew         = r.instr[`VMID_B_MEW];
  assign is_load_dec = (opc == `VMID_OPC_LOAD);
  assign fp_opc      = is_load_dec || (opc == `VMID_OPC_STORE);

  // Codes 001 to 100 stay scalar floating point; the vector codes map to 8..64 bits.
  assign fp_scalar = fp_opc && !mew && (wcode != 3'h0) && (wcode[2] == 1'b0 || wcode[1:0] == 2'b00);
  assign eew_log   = wcode[1:0];

  // Configuration: any nonzero reserved bit or the illegal flag poisons every vector access.
  assign cfg_ew_log = r.vtype[`VMID_F_EW];
  assign cfg_gm_log = {r.vtype[2], r.vtype[`VMID_F_GM]};
  assign gm_bad     = (r.vtype[`VMID_F_GM] == 3'b100);
  assign cfg_bad    = r.vtype[`VMID_B_VILL] || (|r.vtype[30:8]) || r.vtype[`VMID_B_EW_HI] || gm_bad;

  // Effective multiplier in log2 form: encoded width over configured width, times group multiplier.
  assign eff_gm_log = $signed({2'b00, eew_log}) - $signed({2'b00, cfg_ew_log}) + cfg_gm_log;

  assign unit    = (mode_dec == 2'b00);
  assign indexed = mode_dec[0];
  assign mask_x  = unit && (variant == `VMID_V_MASK);
  assign whole   = unit && (variant == `VMID_V_WHOLE);
  assign fof_dec = unit && is_load_dec && (variant == `VMID_V_FOF);

  // Variant legality differs between loads and stores.
  assign var_ok = !unit || (variant == `VMID_V_PLAIN) || (variant == `VMID_V_WHOLE) || (variant == `VMID_V_MASK) ||
                  (is_load_dec && variant == `VMID_V_FOF);

  // Whole-register transfers move 1, 2, 4 or 8 registers.
  assign whole_bad = whole && !(fcount == 3'h0 || fcount == 3'h1 || fcount == 3'h3 || fcount == 3'h7);
  assign whole_log = fcount[2] ? 2'h3 : (fcount[1] ? 2'h2 : {1'b0, fcount[0]});

  // Data group size: indexed data follows the configuration, mask transfers are one register.
  assign data_gm_log = indexed ? cfg_gm_log : (mask_x ? 4'sd0 : (whole ? $signed({2'b00, whole_log}) : eff_gm_log));
  assign align_bad   = !grp_ok(dreg, data_gm_log) || (indexed && !grp_ok(sreg, eff_gm_log));

  // Support checks for data and index widths.
  assign eew_unsup = ((indexed ? `VMID_IDX_SUPPORT : `VMID_EW_SUPPORT) & (4'h1 << eew_log)) == 4'h0;

  assign illegal_dec = !fp_opc || (!fp_scalar && (mew || cfg_bad || !var_ok || whole_bad || align_bad || eew_unsup ||
                       (!mask_x && !whole && (eff_gm_log > 4'sd3 || eff_gm_log < -4'sd3))));

  // Memory element size: encoded for unit and strided, bytes for mask transfers, configured for indexed.
  assign data_log_dec = indexed ? cfg_ew_log : (mask_x ? 2'h0 : eew_log);

  // Mask transfers cover ceil(len/8) bytes; elements are capped at the offset table depth.
  assign evl_mask = ({1'b0, r.vec_len} + 5'h07) >> 3;
  assign evl_dec  = mask_x ? evl_mask[3:0] : ((r.vec_len > `VMID_MAX_ELEMS) ? `VMID_MAX_ELEMS : r.vec_len);

  // Offsets are unscaled byte distances, zero-extended to the register width.
  assign off_raw = r.offv[r.elem[2:0]];
  always_comb begin
    case (r.idx_log)
      2'h0: off_ext = {24'h000000, off_raw[7:0]};
      2'h1: off_ext = {16'h0000, off_raw[15:0]};
      default: off_ext = off_raw;
    endcase
  end

  // Element address, then the field within the segment.
  assign elem_base = r.mode[0] ? r.base + off_ext : r.base + r.step * {28'h0000000, r.elem};
  assign next_addr = elem_base + ({29'h0, r.fld} << r.data_log);

  // A zero mask-enable bit turns masking on.
  assign active = !r.mask_on || r.mask[r.elem[2:0]];

  // Read multiplexer, evaluated one cycle after the address phase so earlier writes are visible.
  always_comb begin
    rd_data = 32'h00000000;
    if (!r.bus_hit) begin
      rd_data = 32'h00000000;
    end else if (r.bus_addr == `VMID_OFF_INSTR) begin
      rd_data = r.instr;
    end else if (r.bus_addr == `VMID_OFF_VTYPE) begin
      rd_data = r.vtype;
    end else if (r.bus_addr == `VMID_OFF_VLEN) begin
      rd_data = {28'h0000000, r.vec_len};
    end else if (r.bus_addr == `VMID_OFF_START) begin
      rd_data = {28'h0000000, r.start_elem};
    end else if (r.bus_addr == `VMID_OFF_MASK) begin
      rd_data = {24'h000000, r.mask};
    end else if (r.bus_addr == `VMID_OFF_STATUS) begin
      rd_data = {26'h0, r.st_trim, r.st_fp, r.st_fault, r.st_illegal, r.st_done,
                 r.state != vmid_pkg::vmid_idle};
    end else if (r.bus_addr == `VMID_OFF_DECODE) begin
      rd_data = {20'h00000, illegal_dec, fp_scalar, eff_gm_log, data_log_dec, eew_log, mode_dec};
    end else if ((r.bus_addr & `VMID_SEL_OFFV) == `VMID_OFF_OFFV) begin
      rd_data = r.offv[r.bus_addr[4:2]];
    end else if ((r.bus_addr & `VMID_SEL_XREG) == `VMID_OFF_XREG) begin
      rd_data = r.xreg[r.bus_addr[6:2]];
    end
  end

  // Next-state logic: bus side first, then the sequencer, so hardware updates win a tie.
  always_comb begin
    n = r;
    n.dest_valid    = 1'b0;
    n.dest_agnostic = 1'b0;
    n.wr_pend       = 1'b0;
    n.rd_pend       = 1'b0;
    n.hreadyout     = 1'b1;
    n.hresp         = 1'b0;

    // Address phase: reads take one wait state so data comes straight from a flop.
    if (hsel && htrans[1] && hready) begin
      n.bus_addr  = haddr[7:0];
      n.bus_hit   = (haddr[31:8] == 24'h000000);
      n.wr_pend   = hwrite;
      n.rd_pend   = !hwrite;
      n.hreadyout = hwrite;
    end
    if (r.rd_pend) begin
      n.hrdata = rd_data;
    end

    // Write data phase; configuration is frozen while an instruction runs.
    if (r.wr_pend && r.bus_hit) begin
      if (r.bus_addr == `VMID_OFF_STATUS) begin
        n.st_done    = r.st_done & !hwdata[1];
        n.st_illegal = r.st_illegal & !hwdata[2];
        n.st_fault   = r.st_fault & !hwdata[3];
        n.st_fp      = r.st_fp & !hwdata[4];
        n.st_trim    = r.st_trim & !hwdata[5];
      end else if (r.state == vmid_pkg::vmid_idle) begin
        if (r.bus_addr == `VMID_OFF_INSTR) begin
          n.instr      = hwdata;
          n.state      = vmid_pkg::vmid_decode;
          n.st_done    = 1'b0;
          n.st_illegal = 1'b0;
          n.st_fault   = 1'b0;
          n.st_fp      = 1'b0;
          n.st_trim    = 1'b0;
        end else if (r.bus_addr == `VMID_OFF_VTYPE) begin
          n.vtype = hwdata;
        end else if (r.bus_addr == `VMID_OFF_VLEN) begin
          n.vec_len = hwdata[3:0];
        end else if (r.bus_addr == `VMID_OFF_START) begin
          n.start_elem = hwdata[3:0];
        end else if (r.bus_addr == `VMID_OFF_MASK) begin
          n.mask = hwdata[7:0];
        end else if ((r.bus_addr & `VMID_SEL_OFFV) == `VMID_OFF_OFFV) begin
          n.offv[r.bus_addr[4:2]] = hwdata;
        end else if ((r.bus_addr & `VMID_SEL_XREG) == `VMID_OFF_XREG && r.bus_addr[6:2] != 5'h00) begin
          n.xreg[r.bus_addr[6:2]] = hwdata;
        end
      end
    end

    // Element sequencer.
    case (r.state)
      vmid_pkg::vmid_idle: begin
        n.req_valid = 1'b0;
      end
      vmid_pkg::vmid_decode: begin
        if (fp_scalar) begin
          n.st_fp   = 1'b1;
          n.st_done = 1'b1;
          n.state   = vmid_pkg::vmid_idle;
        end else if (illegal_dec) begin
          n.st_illegal = 1'b1;
          n.st_done    = 1'b1;
          n.state      = vmid_pkg::vmid_idle;
        end else begin
          n.mode     = vmid_pkg::vmid_mode_type'(mode_dec);
          n.is_load  = is_load_dec;
          n.mask_on  = !r.instr[`VMID_B_MASK_EN];
          n.vma      = r.vtype[`VMID_B_VMA];
          n.fof      = fof_dec;
          n.data_log = data_log_dec;
          n.idx_log  = eew_log;
          n.fld_last = whole ? 3'h0 : fcount;
          n.base     = r.xreg[r.instr[`VMID_F_BASE]];
          // Unit stride advances by one whole segment, strided by the scalar stride.
          n.step     = unit ? ({29'h0, (whole ? 3'h0 : fcount)} + 32'h00000001) << data_log_dec : r.xreg[sreg];
          n.evl      = evl_dec;
          n.elem     = r.start_elem;
          n.fld      = 3'h0;
          n.state    = vmid_pkg::vmid_issue;
        end
      end
      vmid_pkg::vmid_issue: begin
        if (r.elem >= r.evl) begin
          n.st_done    = 1'b1;
          n.start_elem = 4'h0;
          n.state      = vmid_pkg::vmid_idle;
        end else if (!active) begin
          // Inactive elements are skipped; only an agnostic load may overwrite them.
          n.dest_valid    = r.is_load && r.vma;
          n.dest_agnostic = r.is_load && r.vma;
          n.dest_elem     = r.elem[2:0];
          n.elem          = r.elem + 4'h1;
        end else if (!r.req_valid) begin
          n.req_valid   = 1'b1;
          n.req_addr    = next_addr;
          n.req_write   = !r.is_load;
          n.req_size    = r.data_log;
          n.req_elem    = r.elem[2:0];
          n.req_field   = r.fld;
          n.req_ordered = (r.mode == vmid_pkg::vmid_idx_ord);
        end else if (mem_req_ready) begin
          n.req_valid = 1'b0;
          n.state     = vmid_pkg::vmid_wait;
        end
      end
      vmid_pkg::vmid_wait: begin
        // One access in flight keeps every mode in element order and every fault precise.
        if (mem_resp_valid) begin
          if (mem_resp_fault) begin
            if (r.fof && r.elem != 4'h0) begin
              n.vec_len    = r.elem;
              n.st_trim    = 1'b1;
              n.st_done    = 1'b1;
              n.start_elem = 4'h0;
            end else begin
              n.st_fault   = 1'b1;
              n.st_done    = 1'b1;
              n.start_elem = r.elem;
            end
            n.state = vmid_pkg::vmid_idle;
          end else begin
            n.dest_valid = r.is_load && (r.fld == r.fld_last);
            n.dest_elem  = r.elem[2:0];
            if (r.fld == r.fld_last) begin
              n.fld  = 3'h0;
              n.elem = r.elem + 4'h1;
            end else begin
              n.fld = r.fld + 3'h1;
            end
            n.state = vmid_pkg::vmid_issue;
          end
        end
      end
      default: begin
        n.state = vmid_pkg::vmid_idle;
      end
    endcase
  end

  // State register.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      r           <= '0;
      r.vtype     <= `VMID_VTYPE_RST;
      r.hreadyout <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // Outputs come straight from the state record.
  assign hreadyout       = r.hreadyout;
  assign hresp           = r.hresp;
  assign hrdata          = r.hrdata;
  assign mem_req_valid   = r.req_valid;
  assign mem_req_addr    = r.req_addr;
  assign mem_req_write   = r.req_write;
  assign mem_req_size    = r.req_size;
  assign mem_req_elem    = r.req_elem;
  assign mem_req_field   = r.req_field;
  assign mem_req_ordered = r.req_ordered;
  assign dest_valid      = r.dest_valid;
  assign dest_elem       = r.dest_elem;
  assign dest_agnostic   = r.dest_agnostic;

  default clocking chk_cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  chk_inactive_quiet: assert property (
    mem_req_valid |-> (!r.mask_on || r.mask[mem_req_elem]))
    else $error("request issued for an inactive element");

  chk_agnostic_fill: assert property (
    (dest_valid && dest_agnostic) |-> (r.is_load && r.vma))
    else $error("inactive element overwritten without agnostic policy");

  chk_start_index: assert property (
    (r.state == vmid_pkg::vmid_decode && !illegal_dec && !fp_scalar) |=> (r.elem == $past(r.start_elem)))
    else $error("sequence did not begin at the start index");

  chk_fault_start: assert property (
    (r.state == vmid_pkg::vmid_wait && mem_resp_valid && mem_resp_fault && !(r.fof && r.elem != 4'h0))
      |=> (r.st_fault && r.start_elem == $past(r.elem) && r.state == vmid_pkg::vmid_idle))
    else $error("fault did not record the faulting element");

  chk_illegal_quiet: assert property (
    (r.state == vmid_pkg::vmid_decode && illegal_dec && !fp_scalar) |=> (r.st_illegal && !mem_req_valid) [*2])
    else $error("reserved encoding did not stop as illegal");

  chk_base_source: assert property (
    (r.state == vmid_pkg::vmid_decode && !illegal_dec && !fp_scalar) |=> (r.base == $past(r.xreg[r.instr[19:15]])))
    else $error("base not taken from the selected scalar register");

  chk_stride_addr: assert property (
    ($rose(mem_req_valid) && r.mode == vmid_pkg::vmid_strided && mem_req_field == 3'h0)
      |-> (mem_req_addr == r.base + r.step * {28'h0000000, r.elem}))
    else $error("strided element address wrong");

  chk_index_zext: assert property (
    ($rose(mem_req_valid) && r.mode[0] && r.idx_log == 2'h0 && mem_req_field == 3'h0)
      |-> (mem_req_addr == r.base + {24'h000000, r.offv[mem_req_elem][7:0]}))
    else $error("byte index not zero-extended");

  chk_ordered_flag: assert property (
    mem_req_valid |-> (mem_req_ordered == (r.mode == vmid_pkg::vmid_idx_ord)))
    else $error("ordering flag does not match the mode");

  chk_read_wait: assert property (
    (hsel && htrans[1] && hready && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read did not take exactly one wait state");

endmodule

// ===== verification/vmid_mem_model.sv
// Memory-side model for the vector decoder: takes one element request at a time and logs it.
`timescale 1ns/1ns
module vmid_mem_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        mem_req_valid,
  input  wire logic [31:0] mem_req_addr,
  input  wire logic        mem_req_ordered,
  input  wire logic        mem_req_write,
  input  wire logic [1:0]  mem_req_size,
  input  wire logic [31:0] fault_addr,
  input  wire logic        slow,
  output logic             mem_req_ready,
  output logic             mem_resp_valid,
  output logic             mem_resp_fault
);
  logic [35:0] log_q[$];
  logic        pend_q;
  logic        flt_q;
  logic [1:0]  cnt_q;
  // Ready comes a cycle after valid; outside the answer pulse the fault line shows the inverse of the fault flag of the last accepted request.
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mem_req_ready <= 1'b0;
      mem_resp_valid <= 1'b0;
      mem_resp_fault <= 1'b0;
      pend_q <= 1'b0;
      flt_q <= 1'b0;
      cnt_q <= 2'h0;
    end else begin
      mem_resp_valid <= 1'b0;
      mem_resp_fault <= ~flt_q;
      if (pend_q) begin
        cnt_q <= cnt_q - 2'h1;
        if (cnt_q == 2'h0) begin
          pend_q <= 1'b0;
          mem_resp_valid <= 1'b1;
          mem_resp_fault <= flt_q;
        end
      end else if (mem_req_valid && mem_req_ready) begin
        mem_req_ready <= 1'b0;
        pend_q <= 1'b1;
        cnt_q <= slow ? 2'h3 : 2'h0;
        flt_q <= (mem_req_addr == fault_addr);
        log_q.push_back({mem_req_write, mem_req_size, mem_req_ordered, mem_req_addr});
      end else begin
        mem_req_ready <= mem_req_valid;
      end
    end
  end
endmodule

// ===== verification/tb.sv
// Self-checking bench for the vector memory decoder: table of encodings, then faults, start index and reset.
`timescale 1ns/1ns
`include "vmid_map.svh"
module tb;
  typedef struct packed {
    logic [31:0] ins;
    logic [7:0]  vt, msk;
    logic [5:0]  st;
    logic [3:0]  n;
    logic [31:0] a0, step;
    logic [3:0]  att;
  } vmid_row_type;
  localparam logic [6:0] ld = `VMID_OPC_LOAD;
  localparam logic [6:0] sto = `VMID_OPC_STORE;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, mem_req_valid, mem_req_ready, mem_req_write, mem_req_ordered;
  logic mem_resp_valid, mem_resp_fault, dest_valid, dest_agnostic, slow;
  logic [1:0] htrans, mem_req_size;
  logic [2:0] hsize, mem_req_elem, mem_req_field, dest_elem;
  logic [31:0] haddr, hwdata, hrdata, mem_req_addr, fault_addr, r;
  int mismatches, num_checks, agn, k, dv, hr;
  logic [7:0] dm;
  vmid_row_type rows[16];
  vmid_top dut_u (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout,
    .hresp, .hrdata, .mem_req_valid, .mem_req_ready, .mem_req_addr, .mem_req_write, .mem_req_size, .mem_req_elem,
    .mem_req_field, .mem_req_ordered, .mem_resp_valid, .mem_resp_fault, .dest_valid, .dest_elem, .dest_agnostic);
  vmid_mem_model mem_u (.hclk, .hresetn, .mem_req_valid, .mem_req_addr, .mem_req_ordered, .fault_addr, .slow,
    .mem_req_write, .mem_req_size, .mem_req_ready, .mem_resp_valid, .mem_resp_fault);
  function automatic logic [31:0] ins(input logic [2:0] fc, input logic mew, input logic [1:0] mop, input logic men,
    input logic [4:0] sr, input logic [2:0] w, input logic [4:0] dr, input logic [6:0] opc);
    return {fc, mew, mop, men, sr, 5'h01, w, dr, opc};
  endfunction
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    num_checks++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One single AHB transfer; the address phase is held until ready is seen, read data is taken at the last edge.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [31:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  // Launch an instruction, poll until idle, and compare the sticky flags.
  task automatic go(input logic [31:0] i, input logic [5:0] st);
    int t;
    mem_u.log_q.delete();
    wr(`VMID_OFF_INSTR, i);
    t = 0;
    do begin
      rd(`VMID_OFF_STATUS);
      t++;
    end while (r[0] !== 1'b0 && t < 200);
    chk(r[5:0], st);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end
  // Destination and response pulses last one cycle, so they are counted on every edge.
  always @(posedge hclk) begin
    if (dest_valid === 1'b1) dv++;
    if (dest_agnostic === 1'b1) begin
      agn++;
      dm[dest_elem] = 1'b1;
    end
    if (hresp === 1'b1) hr++;
  end
  // The whole run needs a few hundred cycles; 20000 cycles means a hang.
  initial begin
    #80000;
    mismatches++;
    final_report();
  end
  initial begin
    {hresetn, hwrite, htrans, haddr, hwdata, slow, agn, dv, hr, dm} = '0;
    {hsel, hsize, fault_addr} = {1'b1, 3'h2, 32'hFFFFFFFF};
    rows = '{'{ins(0, 0, 0, 1, 0, 6, 8, ld), 8'h10, 8'hFF, 6'h02, 4'h4, 32'h1000, 32'h4, 4'h4},
             '{ins(0, 0, 2, 1, 2, 0, 8, sto), 8'h10, 8'hFF, 6'h02, 4'h4, 32'h1000, 32'h20, 4'h8},
             '{ins(0, 0, 3, 1, 8, 6, 8, ld), 8'h10, 8'hFF, 6'h02, 4'h4, 32'h0F00, 32'hC, 4'h5},
             '{ins(0, 0, 1, 1, 8, 0, 8, sto), 8'h10, 8'hFF, 6'h02, 4'h4, 32'h1000, 32'hC, 4'hC},
             '{ins(0, 0, 0, 0, 0, 6, 8, ld), 8'h90, 8'h05, 6'h02, 4'h4, 32'h1000, 32'h4, 4'h4},
             '{ins(0, 1, 0, 1, 0, 6, 8, ld), 8'h10, 8'hFF, 6'h06, 4'h0, 32'h0, 32'h0, 4'h0},
             '{ins(0, 0, 0, 1, 0, 2, 8, ld), 8'h10, 8'hFF, 6'h12, 4'h0, 32'h0, 32'h0, 4'h0},
             '{ins(0, 0, 0, 1, 1, 6, 8, ld), 8'h10, 8'hFF, 6'h06, 4'h0, 32'h0, 32'h0, 4'h0},
             '{ins(0, 0, 0, 1, 16, 6, 8, sto), 8'h10, 8'hFF, 6'h06, 4'h0, 32'h0, 32'h0, 4'h0},
             '{ins(0, 0, 0, 1, 0, 7, 8, ld), 8'h03, 8'hFF, 6'h06, 4'h0, 32'h0, 32'h0, 4'h0},
             '{ins(0, 0, 0, 1, 0, 6, 1, ld), 8'h11, 8'hFF, 6'h06, 4'h0, 32'h0, 32'h0, 4'h0},
             '{ins(0, 0, 0, 1, 11, 0, 8, ld), 8'h10, 8'hFF, 6'h02, 4'h1, 32'h1000, 32'h1, 4'h0},
             '{ins(0, 0, 0, 1, 0, 6, 8, 7'h03), 8'h10, 8'hFF, 6'h06, 4'h0, 32'h0, 32'h0, 4'h0},
             '{ins(1, 0, 0, 1, 0, 6, 8, ld), 8'h10, 8'hFF, 6'h02, 4'h8, 32'h1000, 32'h4, 4'h4},
             '{ins(0, 0, 0, 1, 0, 6, 8, ld), 8'h20, 8'hFF, 6'h06, 4'h0, 32'h0, 32'h0, 4'h0},
             '{ins(1, 0, 0, 1, 8, 6, 8, ld), 8'h10, 8'hFF, 6'h02, 4'h4, 32'h1000, 32'h4, 4'h4}};
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    wr(`VMID_OFF_XREG + 4, 32'h1000);
    wr(`VMID_OFF_XREG + 8, 32'h20);
    for (int i = 0; i < 8; i++) wr(`VMID_OFF_OFFV + 4 * i, 32'hFFFFFF00 | (12 * i));
    wr(`VMID_OFF_VLEN, 32'h4);
    foreach (rows[j]) begin
      slow <= j[0];
      wr(`VMID_OFF_VTYPE, rows[j].vt);
      wr(`VMID_OFF_MASK, rows[j].msk);
      go(rows[j].ins, rows[j].st);
      k = 0;
      for (int e = 0; e < rows[j].n; e++) if (rows[j].msk[e]) begin
        chk(mem_u.log_q.size() > k ? mem_u.log_q[k] : 'x, {rows[j].att, rows[j].a0 + e * rows[j].step});
        k++;
      end
      chk(mem_u.log_q.size(), k);
    end
    chk(agn, 2);
    chk(dm, 8'h0A);
    chk(dv, 21);
    fault_addr <= 32'h1008;
    wr(`VMID_OFF_VTYPE, 32'h10);
    go(rows[0].ins, 6'h0A);
    rd(`VMID_OFF_START);
    chk(r, 2);
    wr(`VMID_OFF_START, 32'h0);
    go(ins(0, 0, 0, 1, 16, 6, 8, ld), 6'h22);
    rd(`VMID_OFF_VLEN);
    chk(r, 2);
    fault_addr <= 32'hFFFFFFFF;
    wr(`VMID_OFF_VLEN, 32'h4);
    wr(`VMID_OFF_START, 32'h1);
    go(rows[0].ins, 6'h02);
    chk(mem_u.log_q[0], {4'h4, 32'h1004});
    rd(`VMID_OFF_START);
    chk(r, 0);
    wr(`VMID_OFF_XREG, 32'h5);
    rd(`VMID_OFF_XREG);
    chk(r, 0);
    rd(32'h100);
    chk(r, 0);
    rd(`VMID_OFF_VTYPE);
    chk(r, 32'h10);
    // A second reset in mid-run must bring the configuration back to its illegal default.
    hresetn <= 1'b0;
    repeat (3) @(posedge hclk);
    chk({hreadyout, hresp, mem_req_valid, dest_valid, hrdata}, {4'h8, 32'h0});
    hresetn <= 1'b1;
    rd(`VMID_OFF_VTYPE);
    chk(r, `VMID_VTYPE_RST);
    chk(hr, 0);
    final_report();
  end
endmodule
